// ### rtl/tuc_params.svh
/*
  constants of the timer update control block: register indices,
  field positions, reset values and codes.
  assumes inclusion by bare name from the package and the design modules.
*/
`ifndef TUC_PARAMS_SVH
`define TUC_PARAMS_SVH

// register indices as printed; byte address is four times the index
`define TUC_IDX_WAVE 8'h01
`define TUC_IDX_IDLE 8'h02
`define TUC_IDX_SPLIT 8'h03
`define TUC_IDX_ECLR 8'h04
`define TUC_IDX_ESET 8'h05
`define TUC_IDX_FCLR 8'h06
`define TUC_IDX_FSET 8'h07
`define TUC_IDX_CTRL 8'h00

// control word fields
`define TUC_ENABLE_BIT 0
`define TUC_WAVE_MODE_LSB 0
`define TUC_WAVE_MODE_MSB 2
`define TUC_AUTOLOCK_BIT 3
`define TUC_CMPEN_LSB 4
`define TUC_CMPEN_MSB 6
`define TUC_DIR_BIT 0
`define TUC_LOCK_BIT 1
`define TUC_CMD_LSB 2
`define TUC_CMD_MSB 3
`define TUC_SPLIT_BIT 0
`define TUC_PERIOD_BUFFER_VALID_BIT 0
`define TUC_CMPBV_LSB 1
`define TUC_CMPBV_MSB 3

// command codes
`define TUC_CMD_NONE 2'h0
`define TUC_CMD_UPDATE 2'h1
`define TUC_CMD_RESTART 2'h2
`define TUC_CMD_HARDRST 2'h3

// reset values and channel count
`define TUC_RST_BYTE 8'h00
`define TUC_RST_WORD 32'h0000_0000
`define TUC_NUM_CH 3

`endif

// ### rtl/tuc_pkg.sv
/*
  types of the timer update control block.
  assumes tuc_params.svh on the include path.
*/
`include "tuc_params.svh"

package tuc_pkg;

  // waveshape_select codes
  typedef enum logic [2:0] {
    TUC_WAVE_NORMAL = 3'h0,
    TUC_WAVE_FREQUENCY = 3'h1,
    TUC_WAVE_RSV2 = 3'h2,
    TUC_WAVE_ONE_RAMP = 3'h3,
    TUC_WAVE_RSV4 = 3'h4,
    TUC_WAVE_TWO_OVF_TOP = 3'h5,
    TUC_WAVE_TWO_OVF_BOTH = 3'h6,
    TUC_WAVE_TWO_OVF_LOW = 3'h7
  } tuc_wave_e;

  // apb request
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } tuc_apb_req_s;

  // apb answer
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tuc_apb_rsp_s;

  // decoded mode behaviour
  typedef struct packed {
    logic top_is_cmp0;
    logic update_at_bottom;
    logic ovf_at_top;
    logic ovf_at_bottom;
    logic wave_active;
    logic count_down_start;
    logic reserved;
  } tuc_mode_s;

  // datapath events seen by the block
  typedef struct packed {
    logic at_top;
    logic at_bottom;
    logic period_buffer_wr;
    logic [2:0] cmpbuf_wr;
    logic hw_dir_valid;
    logic hw_dir;
  } tuc_evt_s;

endpackage

// ### rtl/tuc_mode_decode.sv
/*
  decodes waveshape_select into top, update and overflow behaviour.
  assumes a registered mode code from the same clock domain.
*/
module tuc_mode_decode (
  // mode in
  input wire logic [2:0] mode,
  // decoded behaviour
  output tuc_pkg::tuc_mode_s info
);

  always_comb begin
    info = '0;
    unique case (tuc_pkg::tuc_wave_e'(mode))
      tuc_pkg::TUC_WAVE_NORMAL: begin
        info.ovf_at_top = 1'b1;
      end
      tuc_pkg::TUC_WAVE_FREQUENCY: begin
        info.top_is_cmp0 = 1'b1;
        info.ovf_at_top = 1'b1;
        info.wave_active = 1'b1;
      end
      tuc_pkg::TUC_WAVE_ONE_RAMP: begin
        info.update_at_bottom = 1'b1;
        info.ovf_at_bottom = 1'b1;
        info.wave_active = 1'b1;
      end
      tuc_pkg::TUC_WAVE_TWO_OVF_TOP: begin
        info.update_at_bottom = 1'b1;
        info.ovf_at_top = 1'b1;
        info.wave_active = 1'b1;
      end
      tuc_pkg::TUC_WAVE_TWO_OVF_BOTH: begin
        info.update_at_bottom = 1'b1;
        info.ovf_at_top = 1'b1;
        info.ovf_at_bottom = 1'b1;
        info.wave_active = 1'b1;
      end
      tuc_pkg::TUC_WAVE_TWO_OVF_LOW: begin
        info.update_at_bottom = 1'b1;
        info.ovf_at_bottom = 1'b1;
        info.wave_active = 1'b1;
      end
      default: begin
        info.reserved = 1'b1;
      end
    endcase
  end

endmodule

// ### rtl/tuc_pin_mux.sv
/*
  per-channel pin routing of the waveform result.
  assumes all inputs from logic on mclk; output is combinational and is
  registered by the parent.
*/
`include "tuc_params.svh"

module tuc_pin_mux (
  // selection
  input wire logic wave_active,
  input wire logic [2:0] cmp_en,
  // sources
  input wire logic [2:0] wave_level,
  input wire logic [2:0] port_level,
  // result
  output logic [2:0] pin_level,
  output logic [2:0] pin_override
);

  genvar ch;
  generate
    for (ch = 0; ch < `TUC_NUM_CH; ch++) begin : g_ch
      // enabled channel overrides the port register in waveform modes, not in normal or reserved modes
      assign pin_override[ch] = wave_active & cmp_en[ch];
      assign pin_level[ch] = pin_override[ch] ? wave_level[ch]
                                              : port_level[ch];
    end
  endgenerate

endmodule

// ### rtl/tuc_top.sv
/*
  timer update control: control registers, lock-update handling,
  buffer-valid tracking, command decode and waveform pin routing.
  assumes an apb master on mclk and a counter datapath that reports
  top/bottom events and buffer writes; port levels come from pins.
*/
`include "tuc_params.svh"

//Overview of operation
// - auto-lock holds update_lock set until all enabled compare buffers valid
// - once cleared, update_lock stays clear until update, then sets again
// - without auto-lock only software changes update_lock
// - mode 000 normal, 001 frequency with cmp0 top; 010, 100 reserved
// - mode 011 one-ramp pwm: update and overflow at bottom
// - modes 101-111 two-ramp: update bottom, overflow top, both or bottom
// - normal mode drives no waveform onto pins
// - waveform reaches a pin only with its compare_output_enable set
// - while disabled, compare_output_level writes drive waveform outputs
// - dual_8bit_select splits unit into two 8-bit counters
// - writing one in the E clear register clears that bit
// - writing one in the E set register sets that bit
// - E set and E clear addresses read the same status
// - command 1 update, 2 restart, 3 hard reset unless enabled
// - command field always reads zero
// - update_lock set blocks buffer copy on update
// - update_lock clear lets update copy buffers at once
// - direction bit: 0 up, 1 down; hardware or software may write
// - compare_buffer_valid set on buffer write, cleared on update
// - period_buffer_valid set on buffer write, cleared on update
// - writing one to F clear clears only that valid bit
// - in waveform modes a set enable overrides the port output
module tuc_top (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // apb slave
  input wire tuc_pkg::tuc_apb_req_s apb_req,
  output tuc_pkg::tuc_apb_rsp_s apb_rsp,
  // datapath events
  input wire tuc_pkg::tuc_evt_s evt,
  input wire logic [2:0] wave_result,
  // port output register levels from pins
  input wire logic [2:0] port_level_pin,
  // control to datapath
  output logic timer_enable,
  output logic [2:0] waveshape_select,
  output logic count_dir,
  output logic dual_8bit_select,
  output logic copy_buffers,
  output logic restart_pulse,
  output logic hard_reset_pulse,
  output logic top_is_cmp0,
  output logic [2:0] wave_level,
  // pins
  output logic [2:0] pin_level,
  output logic [2:0] pin_override
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] port_m;
    logic [2:0] port_s;
    logic enable;
    logic [2:0] wave_mode;
    logic auto_lock_enable;
    logic [2:0] compare_output_enable;
    logic [2:0] compare_output_level;
    logic dual_8bit_select;
    logic update_lock;
    logic dir;
    logic period_buffer_valid;
    logic [2:0] compare_buffer_valid;
    logic copy;
    logic restart;
    logic hard_reset;
    logic top_cmp0;
    logic [2:0] pin_level;
    logic [2:0] pin_override;
    tuc_pkg::tuc_apb_rsp_s rsp;
  } tuc_state_s;

  tuc_state_s r;
  tuc_state_s next_r;
  tuc_pkg::tuc_mode_s mode_info;
  logic [2:0] mux_level;
  logic [2:0] mux_override;
  logic [2:0] live_wave;

  // word index of a byte address; -1 pattern when unaligned or at byte address 0x400 and above
  function automatic logic [7:0] reg_index(input logic [31:0] addr);
    if (addr[1:0] != 2'h0 || addr[31:10] != 22'h0) begin
      reg_index = 8'hff;
    end else begin
      reg_index = addr[9:2];
    end
  endfunction

  tuc_mode_decode u_mode (
    .mode(r.wave_mode),
    .info(mode_info)
  );

  // waveform value: level bits while stopped, generator while running
  assign live_wave = r.enable ? wave_result : r.compare_output_level;

  tuc_pin_mux u_mux (
    .wave_active(mode_info.wave_active),
    .cmp_en(r.compare_output_enable),
    .wave_level(live_wave),
    .port_level(r.port_s),
    .pin_level(mux_level),
    .pin_override(mux_override)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic [7:0] wb;
  logic update_evt;
  logic [2:0] en_mask;
  logic [1:0] cmd;
  logic [7:0] rdata;

  always_comb begin
    next_r = r;
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    rd = apb_req.psel & ~apb_req.pwrite;
    idx = reg_index(apb_req.paddr);
    wb = apb_req.pwdata[7:0];
    cmd = `TUC_CMD_NONE;
    rdata = `TUC_RST_BYTE;
    // pin sampling, two flops
    next_r.port_m = port_level_pin;
    next_r.port_s = r.port_m;
    next_r.copy = 1'b0;
    next_r.restart = 1'b0;
    next_r.hard_reset = 1'b0;
    // apb: zero wait state answer
    next_r.rsp.pready = apb_req.psel & ~apb_req.penable;
    next_r.rsp.pslverr = 1'b0;
    next_r.rsp.prdata = `TUC_RST_WORD;

    // register writes
    if (wr & r.rsp.pready) begin
      unique case (idx)
        `TUC_IDX_CTRL: next_r.enable = wb[`TUC_ENABLE_BIT];
        `TUC_IDX_WAVE: begin
          next_r.wave_mode = wb[`TUC_WAVE_MODE_MSB:`TUC_WAVE_MODE_LSB];
          next_r.auto_lock_enable = wb[`TUC_AUTOLOCK_BIT];
          // arming auto-lock locks at once until the buffers are valid
          if (wb[`TUC_AUTOLOCK_BIT]) next_r.update_lock = 1'b1;
          next_r.compare_output_enable = wb[`TUC_CMPEN_MSB:`TUC_CMPEN_LSB];
        end
        `TUC_IDX_IDLE: begin
          if (!r.enable) begin
            next_r.compare_output_level = wb[2:0];
          end
        end
        `TUC_IDX_SPLIT: next_r.dual_8bit_select = wb[`TUC_SPLIT_BIT];
        `TUC_IDX_ECLR: begin
          if (wb[`TUC_LOCK_BIT]) next_r.update_lock = 1'b0;
          if (wb[`TUC_DIR_BIT]) next_r.dir = 1'b0;
          cmd = wb[`TUC_CMD_MSB:`TUC_CMD_LSB];
        end
        `TUC_IDX_ESET: begin
          if (wb[`TUC_LOCK_BIT]) next_r.update_lock = 1'b1;
          if (wb[`TUC_DIR_BIT]) next_r.dir = 1'b1;
          cmd = wb[`TUC_CMD_MSB:`TUC_CMD_LSB];
        end
        `TUC_IDX_FCLR: begin
          if (wb[`TUC_PERIOD_BUFFER_VALID_BIT]) next_r.period_buffer_valid = 1'b0;
          next_r.compare_buffer_valid = r.compare_buffer_valid &
              ~wb[`TUC_CMPBV_MSB:`TUC_CMPBV_LSB];
        end
        `TUC_IDX_FSET: begin
          if (wb[`TUC_PERIOD_BUFFER_VALID_BIT]) next_r.period_buffer_valid = 1'b1;
          next_r.compare_buffer_valid = r.compare_buffer_valid |
              wb[`TUC_CMPBV_MSB:`TUC_CMPBV_LSB];
        end
        default: ;
      endcase
    end

    // hardware direction from mode or event action
    if (evt.hw_dir_valid) begin
      next_r.dir = evt.hw_dir;
    end

    // command decode
    unique case (cmd)
      `TUC_CMD_UPDATE: ;
      `TUC_CMD_RESTART: next_r.restart = 1'b1;
      `TUC_CMD_HARDRST: next_r.hard_reset = ~r.enable;
      default: ;
    endcase

    // update condition per mode
    update_evt = (cmd == `TUC_CMD_UPDATE) | (r.enable &
        (mode_info.update_at_bottom ? evt.at_bottom : evt.at_top));

    if (update_evt) begin
      next_r.copy = ~r.update_lock;
      if (!r.update_lock) begin
        next_r.period_buffer_valid = 1'b0;
        next_r.compare_buffer_valid = '0;
      end
      if (r.auto_lock_enable) begin
        next_r.update_lock = 1'b1;
      end
    end

    // buffer writes set valid, winning over the update clear
    if (evt.period_buffer_wr) next_r.period_buffer_valid = 1'b1;
    next_r.compare_buffer_valid = next_r.compare_buffer_valid |
        evt.cmpbuf_wr;

    // auto-lock release once every enabled channel holds a valid buffer
    en_mask = r.compare_output_enable;
    if (r.auto_lock_enable && !update_evt &&
        ((r.compare_buffer_valid & en_mask) == en_mask)) begin
      next_r.update_lock = 1'b0;
    end

    // hard reset returns the control state to reset values
    if (r.hard_reset) begin
      next_r.wave_mode = '0;
      next_r.auto_lock_enable = 1'b0;
      next_r.compare_output_enable = '0;
      next_r.compare_output_level = '0;
      next_r.dual_8bit_select = 1'b0;
      next_r.update_lock = 1'b0;
      next_r.dir = 1'b0;
      next_r.period_buffer_valid = 1'b0;
      next_r.compare_buffer_valid = '0;
    end

    // read data
    unique case (idx)
      `TUC_IDX_CTRL: rdata = {7'h00, r.enable};
      `TUC_IDX_WAVE: rdata = {1'b0, r.compare_output_enable,
                              r.auto_lock_enable, r.wave_mode};
      `TUC_IDX_IDLE: rdata = {5'h00, r.compare_output_level};
      `TUC_IDX_SPLIT: rdata = {7'h00, r.dual_8bit_select};
      `TUC_IDX_ECLR, `TUC_IDX_ESET:
        rdata = {6'h00, r.update_lock, r.dir};
      `TUC_IDX_FCLR, `TUC_IDX_FSET:
        rdata = {4'h0, r.compare_buffer_valid, r.period_buffer_valid};
      default: rdata = `TUC_RST_BYTE;
    endcase
    if (rd && !apb_req.penable) begin
      next_r.rsp.prdata = {24'h000000, rdata};
    end
    if (apb_req.psel && !apb_req.penable && idx == 8'hff) begin
      next_r.rsp.pslverr = 1'b1;
    end

    next_r.pin_level = mux_level;
    next_r.pin_override = mux_override;
    next_r.top_cmp0 = mode_info.top_is_cmp0;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign apb_rsp = r.rsp;
  assign timer_enable = r.enable;
  assign waveshape_select = r.wave_mode;
  assign count_dir = r.dir;
  assign dual_8bit_select = r.dual_8bit_select;
  assign copy_buffers = r.copy;
  assign restart_pulse = r.restart;
  assign hard_reset_pulse = r.hard_reset;
  assign top_is_cmp0 = r.top_cmp0;
  assign wave_level = r.compare_output_level;
  assign pin_level = r.pin_level;
  assign pin_override = r.pin_override;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_lock_copy;
    @(posedge mclk) disable iff (sys_rst)
      r.copy |-> !$past(r.update_lock);
  endproperty
  a_lock_copy: assert property (p_lock_copy)
    else $error("buffer copy while locked");

  property p_unlock_copy;
    @(posedge mclk) disable iff (sys_rst)
      (clk_en && r.enable && !r.update_lock && !mode_info.update_at_bottom
       && evt.at_top) |=> r.copy;
  endproperty
  a_unlock_copy: assert property (p_unlock_copy)
    else $error("no copy on update while unlocked");

  property p_autolock_release;
    @(posedge mclk) disable iff (sys_rst)
      (clk_en && r.auto_lock_enable && r.update_lock && !update_evt &&
       !r.hard_reset && (r.compare_buffer_valid &
       r.compare_output_enable) == r.compare_output_enable)
      |=> !r.update_lock;
  endproperty
  a_autolock_release: assert property (p_autolock_release)
    else $error("auto-lock did not release");

  property p_relock;
    @(posedge mclk) disable iff (sys_rst)
      (clk_en && r.auto_lock_enable && update_evt && !r.hard_reset)
      |=> r.update_lock;
  endproperty
  a_relock: assert property (p_relock)
    else $error("lock not set again on update");

  property p_hw_hands_off;
    @(posedge mclk) disable iff (sys_rst)
      (clk_en && !r.auto_lock_enable && !(wr && r.rsp.pready) &&
       !r.hard_reset) |=> $stable(r.update_lock);
  endproperty
  a_hw_hands_off: assert property (p_hw_hands_off)
    else $error("lock moved without auto-lock");

  property p_cmd_zero;
    @(posedge mclk) disable iff (sys_rst)
      (apb_rsp.pready && (reg_index(apb_req.paddr) == `TUC_IDX_ESET))
      |-> apb_rsp.prdata[3:2] == 2'h0;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero)
    else $error("command field read non-zero");

  property p_hardrst_enabled;
    @(posedge mclk) disable iff (sys_rst)
      hard_reset_pulse |-> !$past(r.enable);
  endproperty
  a_hardrst_enabled: assert property (p_hardrst_enabled)
    else $error("hard reset taken while enabled");

  property p_normal_no_wave;
    @(posedge mclk) disable iff (sys_rst)
      (clk_en && r.wave_mode == 3'h0) |=> pin_override == 3'h0;
  endproperty
  a_normal_no_wave: assert property (p_normal_no_wave)
    else $error("pin override in normal mode");

endmodule

// ### sim/tuc_top_tb.sv
/*
  self-checking bench of tuc_top: apb register traffic, datapath events,
  commands, lock-update handling and pin routing.
  assumes tuc_pkg compiled first and tuc_params.svh on the include path.
*/
`include "tuc_params.svh"

module tuc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  tuc_pkg::tuc_apb_req_s apb_req = '0;
  tuc_pkg::tuc_apb_rsp_s apb_rsp;
  tuc_pkg::tuc_evt_s evt = '0;
  logic [2:0] wave_result = 3'h0;
  logic [2:0] port_level_pin = 3'h0;
  logic timer_enable, count_dir, dual_8bit_select, copy_buffers;
  logic restart_pulse, hard_reset_pulse, top_is_cmp0;
  logic [2:0] waveshape_select, wave_level, pin_level, pin_override;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [2:0] en, ov;
  int error_cnt = 0;
  int cmp_count = 0;
  int copy_cnt = 0;
  int rs_cnt = 0;
  int hr_cnt = 0;
  int c;
  int md[4] = '{0, 1, 3, 6};

  always #5 mclk = ~mclk;

  tuc_top i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(1'h1),
    .apb_req(apb_req), .apb_rsp(apb_rsp),
    .evt(evt), .wave_result(wave_result),
    .port_level_pin(port_level_pin),
    .timer_enable(timer_enable), .waveshape_select(waveshape_select),
    .count_dir(count_dir), .dual_8bit_select(dual_8bit_select),
    .copy_buffers(copy_buffers), .restart_pulse(restart_pulse),
    .hard_reset_pulse(hard_reset_pulse), .top_is_cmp0(top_is_cmp0),
    .wave_level(wave_level), .pin_level(pin_level),
    .pin_override(pin_override)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] ba(input logic [7:0] idx);
    return {22'h0, idx, 2'h0};
  endfunction

  // one apb transfer: setup, then access held until pready
  task automatic apb(input logic wr_en, input logic [31:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    apb_req <= '{psel:1'h1, penable:1'h0, pwrite:wr_en, paddr:a, pwdata:d};
    @(posedge mclk);
    apb_req.penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (apb_rsp.pready !== 1'h1 && n < 16);
    apb_req <= '0;
    if (apb_rsp.pready !== 1'h1) begin
      error_cnt++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'h1, ba(idx), d);
  endtask

  // the expected read value is noted before the transfer starts
  task automatic rd(input logic [7:0] idx, input logic [31:0] d);
    exp_q.push_back({1'h0, d});
    apb(1'h0, ba(idx), 32'h0);
  endtask

  task automatic ev(input logic [8:0] v);
    @(posedge mclk);
    // stimulus word: 8 top, 7 bottom, 6 period buffer, 5:3 compare
    // buffers, 2 spare, 1 direction valid, 0 direction
    evt <= '{at_top:v[8], at_bottom:v[7], period_buffer_wr:v[6],
             cmpbuf_wr:v[5:3], hw_dir_valid:v[1], hw_dir:v[0]};
    @(posedge mclk);
    evt <= '0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic settle;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask

  // ----------------------------------------------------------------
  // monitor: read data against oldest note, pulse counting
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (apb_req.psel && apb_req.penable && !apb_req.pwrite &&
        apb_rsp.pready === 1'h1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("wrong value read note expected one seen none");
      end else begin
        e = exp_q.pop_front();
        check("pslverr", apb_rsp.pslverr, e[32]);
        check("prdata", apb_rsp.prdata, e[31:0]);
      end
    end
    if (copy_buffers === 1'h1) copy_cnt++;
    if (restart_pulse === 1'h1) rs_cnt++;
    if (hard_reset_pulse === 1'h1) hr_cnt++;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h62fe));
    repeat (20) @(posedge mclk);
    sys_rst <= 1'h0;
    for (int i = 0; i < 8; i++) rd(8'(i), 32'h0);
    wr(8'h08, 32'h0000_00ff);
    rd(8'h08, 32'h0);
    // unaligned word address answers with an error and zero data
    exp_q.push_back({1'h1, 32'h0});
    apb(1'h0, 32'h0000_0015, 32'h0);
    wr(`TUC_IDX_SPLIT, 32'h1);
    rd(`TUC_IDX_SPLIT, 32'h1);
    settle();
    check("split", dual_8bit_select, 32'h1);
    wr(`TUC_IDX_ESET, 32'h03);
    rd(`TUC_IDX_ECLR, 32'h03);
    rd(`TUC_IDX_ESET, 32'h03);
    settle();
    check("dir", count_dir, 32'h1);
    wr(`TUC_IDX_ESET, 32'h00);
    rd(`TUC_IDX_ESET, 32'h03);
    wr(`TUC_IDX_ECLR, 32'h01);
    rd(`TUC_IDX_ECLR, 32'h02);
    ev(9'h003);
    rd(`TUC_IDX_ESET, 32'h03);
    wr(`TUC_IDX_ECLR, 32'h01);
    ev(9'h048);
    rd(`TUC_IDX_FCLR, 32'h03);
    wr(`TUC_IDX_FCLR, 32'h02);
    rd(`TUC_IDX_FSET, 32'h01);
    // count events only reach the update logic while running
    wr(`TUC_IDX_CTRL, 32'h01);
    wr(`TUC_IDX_FSET, 32'h0e);
    c = copy_cnt;
    ev(9'h100);
    check("locked copy", copy_cnt, c);
    wr(`TUC_IDX_ECLR, 32'h02);
    ev(9'h100);
    check("copy", copy_cnt, c + 1);
    rd(`TUC_IDX_FCLR, 32'h00);
    rd(`TUC_IDX_ESET, 32'h00);
    // update point per waveshape code
    for (int m = 0; m < 8; m++) begin
      wr(`TUC_IDX_WAVE, m);
      settle();
      check("mode", waveshape_select, m);
      check("top cmp0", top_is_cmp0, m == 1);
      c = copy_cnt;
      ev(9'h100);
      if (m != 2 && m != 4)
        check("top copy", copy_cnt - c, m < 2);
      ev(9'h080);
      if (m != 2 && m != 4)
        check("copies", copy_cnt - c, 1);
    end
    // commands while stopped
    wr(`TUC_IDX_CTRL, 32'h00);
    wr(`TUC_IDX_WAVE, 32'h0);
    wr(`TUC_IDX_ESET, 32'h0c);
    settle();
    check("hard reset", hr_cnt, 1);
    rd(`TUC_IDX_ECLR, 32'h00);
    wr(`TUC_IDX_ESET, 32'h08);
    settle();
    check("restart", rs_cnt, 1);
    c = copy_cnt;
    wr(`TUC_IDX_ESET, 32'h04);
    settle();
    check("force copy", copy_cnt, c + 1);
    rd(`TUC_IDX_ESET, 32'h00);
    wr(`TUC_IDX_IDLE, 32'h05);
    settle();
    check("wave level", wave_level, 32'h5);
    // running
    wr(`TUC_IDX_CTRL, 32'h01);
    wr(`TUC_IDX_ESET, 32'h0c);
    wr(`TUC_IDX_IDLE, 32'h02);
    rd(`TUC_IDX_IDLE, 32'h05);
    settle();
    check("enable", timer_enable, 32'h1);
    check("hard reset run", hr_cnt, 1);
    for (int k = 0; k < 4; k++) begin
      en = 3'($urandom);
      wr(`TUC_IDX_WAVE, {25'h0, en, 1'h0, 3'(md[k])});
      wave_result <= 3'($urandom);
      port_level_pin <= 3'($urandom);
      settle();
      ov = (md[k] == 0) ? 3'h0 : en;
      check("override", pin_override, ov);
      e = {30'h0, (wave_result & ov) | (port_level_pin & ~ov)};
      check("pin", pin_level, e[31:0]);
    end
    // auto-lock with channels 0 and 1 enabled
    wr(`TUC_IDX_FCLR, 32'h0f);
    wr(`TUC_IDX_WAVE, 32'h38);
    wr(`TUC_IDX_ECLR, 32'h01);
    rd(`TUC_IDX_ECLR, 32'h02);
    ev(9'h008);
    rd(`TUC_IDX_ECLR, 32'h02);
    ev(9'h010);
    rd(`TUC_IDX_ECLR, 32'h00);
    c = copy_cnt;
    ev(9'h100);
    check("auto copy", copy_cnt, c + 1);
    rd(`TUC_IDX_ESET, 32'h02);
    settle();
    end_sim();
  end
endmodule
